// [design/azbs_pkg.sv]
// Constants and types for the arc zone blocking and status block
package azbs_pkg;
  localparam int unsigned NUM_ZONES    = 4;
  localparam int unsigned NUM_CHAN     = 4;
  localparam int unsigned CODE_W       = 5;
  localparam int unsigned TIME_W       = 32;
  localparam int unsigned CUR_W        = 16;
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned BLOCK_LEAD_MS = 5;
  localparam int unsigned BLOCK_LEAD_CYC = (BLOCK_LEAD_MS * (CLK_HZ / 1000));
  localparam logic [CODE_W-1:0] SC_PH_BLOCKED  = 5'h00;
  localparam logic [CODE_W-1:0] SC_PH_START    = 5'h01;
  localparam logic [CODE_W-1:0] SC_RES_BLOCKED = 5'h02;
  localparam logic [CODE_W-1:0] SC_RES_START   = 5'h03;
  localparam logic [CODE_W-1:0] SC_CHAN_BASE   = 5'h04;
  localparam logic [CODE_W-1:0] SC_DIG_INPUT   = 5'h0C;
  localparam logic [CODE_W-1:0] SC_FAULT_BASE  = 5'h0D;
  localparam logic [CODE_W-1:0] SC_IO_FAULT    = 5'h11;
  localparam logic [CODE_W-1:0] SC_NONE        = 5'h1F;
  localparam logic [3:0]        ZC_NONE        = 4'hF;
  localparam logic [1:0]        FT_PHASE       = 2'h1;
  localparam logic [1:0]        FT_RESIDUAL    = 2'h2;
  localparam logic [1:0]        FT_SENSOR      = 2'h0;
  typedef enum logic [1:0] {
    AZBS_DI_OFF     = 2'b00,
    AZBS_DI_LIGHT   = 2'b01,
    AZBS_DI_CURRENT = 2'b10
  } azbs_di_mode_t;
endpackage

// [design/azbs_top.sv]
// Arc zone blocking decision, event capture and status codes
`timescale 1ns/1ps
module azbs_top
  import azbs_pkg::*;
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,
  input  wire logic                          cycle_tick_i,
  input  wire logic                          block_i,
  input  wire logic [TIME_W-1:0]             time_i,
  input  wire logic [CUR_W-1:0]              cur_a_i,
  input  wire logic [CUR_W-1:0]              cur_b_i,
  input  wire logic [CUR_W-1:0]              cur_c_i,
  input  wire logic [CUR_W-1:0]              cur_res_i,
  input  wire logic [NUM_ZONES-1:0]          zone_en_i,
  input  wire logic [NUM_ZONES-1:0]          zone_ph_en_i,
  input  wire logic [NUM_ZONES-1:0]          zone_res_en_i,
  input  wire logic [NUM_ZONES*NUM_CHAN-1:0] zone_light_en_i,
  input  wire logic [NUM_ZONES*NUM_CHAN-1:0] zone_pres_en_i,
  input  wire logic [NUM_ZONES*2-1:0]        zone_di_mode_i,
  input  wire logic                          ph_start_i,
  input  wire logic                          res_start_i,
  input  wire logic [NUM_CHAN-1:0]           light_i,
  input  wire logic [NUM_CHAN-1:0]           pres_i,
  input  wire logic                          di_i,
  input  wire logic [NUM_CHAN-1:0]           sensor_fault_i,
  input  wire logic                          io_unit_fault_i,
  output logic [NUM_ZONES-1:0]               zone_trip_o,
  output logic [NUM_ZONES-1:0]               zone_blocked_o,
  output logic                               display_notice_o,
  output logic                               block_evt_o,
  output logic [TIME_W-1:0]                  evt_time_o,
  output logic [CUR_W-1:0]                   evt_cur_a_o,
  output logic [CUR_W-1:0]                   evt_cur_b_o,
  output logic [CUR_W-1:0]                   evt_cur_c_o,
  output logic [CUR_W-1:0]                   evt_cur_res_o,
  output logic [1:0]                         evt_fault_type_o,
  output logic [NUM_ZONES-1:0]               evt_zones_o,
  output logic [3:0]                         zone_condition_code_o,
  output logic [CODE_W-1:0]                  sensor_status_o
);
  logic                 blk_smp_ff, nxt_blk_smp;
  logic                 eval_ff, nxt_eval;
  logic [NUM_ZONES-1:0] trip_w;
  logic [NUM_ZONES-1:0] blk_w;
  logic [NUM_ZONES-1:0] evt_w;
  logic                 notice_ff, nxt_notice;
  logic                 evt_ff, nxt_evt;
  logic [TIME_W-1:0]    time_ff, nxt_time;
  logic [CUR_W-1:0]     ca_ff, nxt_ca;
  logic [CUR_W-1:0]     cb_ff, nxt_cb;
  logic [CUR_W-1:0]     cc_ff, nxt_cc;
  logic [CUR_W-1:0]     cr_ff, nxt_cr;
  logic [1:0]           ft_ff, nxt_ft;
  logic [NUM_ZONES-1:0] ez_ff, nxt_ez;
  logic [3:0]           zc_ff, nxt_zc;
  logic [CODE_W-1:0]    sc_ff, nxt_sc;

  always_comb begin
    nxt_blk_smp = cycle_tick_i ? block_i : blk_smp_ff;
    nxt_eval    = cycle_tick_i;
  end

  // Zone decision slices
  genvar z;
  generate
    for (z = 0; z < NUM_ZONES; z++) begin : g_zone
      azbs_zone u_zone (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .eval_i      (eval_ff),
        .block_i     (blk_smp_ff),
        .enable_i    (zone_en_i[z]),
        .ph_en_i     (zone_ph_en_i[z]),
        .res_en_i    (zone_res_en_i[z]),
        .light_en_i  (zone_light_en_i[z*NUM_CHAN +: NUM_CHAN]),
        .pres_en_i   (zone_pres_en_i[z*NUM_CHAN +: NUM_CHAN]),
        .di_mode_i   (zone_di_mode_i[z*2 +: 2]),
        .ph_start_i  (ph_start_i),
        .res_start_i (res_start_i),
        .light_i     (light_i),
        .pres_i      (pres_i),
        .di_i        (di_i),
        .trip_o      (trip_w[z]),
        .blocked_o   (blk_w[z]),
        .block_evt_o (evt_w[z])
      );
    end
  endgenerate

  always_comb begin
    nxt_notice = 1'b0;
    nxt_evt    = 1'b0;
    nxt_time   = time_ff;
    nxt_ca     = ca_ff;
    nxt_cb     = cb_ff;
    nxt_cc     = cc_ff;
    nxt_cr     = cr_ff;
    nxt_ft     = ft_ff;
    nxt_ez     = ez_ff;
    if (|evt_w) begin
      nxt_notice = 1'b1;
      nxt_evt    = 1'b1;
      nxt_time   = time_i;
      nxt_ca     = cur_a_i;
      nxt_cb     = cur_b_i;
      nxt_cc     = cur_c_i;
      nxt_cr     = cur_res_i;
      nxt_ez     = evt_w;
      nxt_ft     = ph_start_i ? FT_PHASE : (res_start_i ? FT_RESIDUAL : FT_SENSOR);
    end
  end

  always_comb begin
    nxt_zc = ZC_NONE;
    for (int i = NUM_ZONES - 1; i >= 0; i--) begin
      if (trip_w[i]) begin
        nxt_zc = 4'(2 * i);
      end else if (blk_w[i]) begin
        nxt_zc = 4'(2 * i + 1);
      end
    end
  end

  always_comb begin
    nxt_sc = SC_NONE;
    if (io_unit_fault_i) begin
      nxt_sc = SC_IO_FAULT;
    end else if (|sensor_fault_i) begin
      for (int c = NUM_CHAN - 1; c >= 0; c--) begin
        if (sensor_fault_i[c]) begin
          nxt_sc = SC_FAULT_BASE + CODE_W'(c);
        end
      end
    end else if (ph_start_i) begin
      nxt_sc = blk_smp_ff ? SC_PH_BLOCKED : SC_PH_START;
    end else if (res_start_i) begin
      nxt_sc = blk_smp_ff ? SC_RES_BLOCKED : SC_RES_START;
    end else if ((|light_i) || (|pres_i)) begin
      for (int c = NUM_CHAN - 1; c >= 0; c--) begin
        if (pres_i[c]) begin
          nxt_sc = SC_CHAN_BASE + CODE_W'(2 * c + 1);
        end
        if (light_i[c]) begin
          nxt_sc = SC_CHAN_BASE + CODE_W'(2 * c);
        end
      end
    end else if (di_i) begin
      nxt_sc = SC_DIG_INPUT;
    end
  end

  // Sample and evaluation registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      blk_smp_ff <= 1'b0;
      eval_ff    <= 1'b0;
    end else begin
      blk_smp_ff <= nxt_blk_smp;
      eval_ff    <= nxt_eval;
    end
  end

  // Event registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      notice_ff  <= 1'b0;
      evt_ff     <= 1'b0;
      time_ff    <= '0;
      ca_ff      <= '0;
      cb_ff      <= '0;
      cc_ff      <= '0;
      cr_ff      <= '0;
      ft_ff      <= FT_SENSOR;
      ez_ff      <= '0;
    end else begin
      notice_ff  <= nxt_notice;
      evt_ff     <= nxt_evt;
      time_ff    <= nxt_time;
      ca_ff      <= nxt_ca;
      cb_ff      <= nxt_cb;
      cc_ff      <= nxt_cc;
      cr_ff      <= nxt_cr;
      ft_ff      <= nxt_ft;
      ez_ff      <= nxt_ez;
    end
  end

  // Condition code register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      zc_ff <= ZC_NONE;
    end else begin
      zc_ff <= nxt_zc;
    end
  end

  // Sensor status register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sc_ff <= SC_NONE;
    end else begin
      sc_ff <= nxt_sc;
    end
  end

  assign zone_trip_o           = trip_w;
  assign zone_blocked_o        = blk_w;
  assign display_notice_o      = notice_ff;
  assign block_evt_o           = evt_ff;
  assign evt_time_o            = time_ff;
  assign evt_cur_a_o           = ca_ff;
  assign evt_cur_b_o           = cb_ff;
  assign evt_cur_c_o           = cc_ff;
  assign evt_cur_res_o         = cr_ff;
  assign evt_fault_type_o      = ft_ff;
  assign evt_zones_o           = ez_ff;
  assign zone_condition_code_o = zc_ff;
  assign sensor_status_o       = sc_ff;
endmodule

// [design/azbs_zone.sv]
// One zone: pick-up logic and trip or blocked decision
`timescale 1ns/1ps
module azbs_zone
  import azbs_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  input  wire logic                eval_i,
  input  wire logic                block_i,
  input  wire logic                enable_i,
  input  wire logic                ph_en_i,
  input  wire logic                res_en_i,
  input  wire logic [NUM_CHAN-1:0] light_en_i,
  input  wire logic [NUM_CHAN-1:0] pres_en_i,
  input  wire logic [1:0]          di_mode_i,
  input  wire logic                ph_start_i,
  input  wire logic                res_start_i,
  input  wire logic [NUM_CHAN-1:0] light_i,
  input  wire logic [NUM_CHAN-1:0] pres_i,
  input  wire logic                di_i,
  output logic                     trip_o,
  output logic                     blocked_o,
  output logic                     block_evt_o
);
  logic pickup;
  logic sens;
  logic cur_ok;
  logic trip_ff, nxt_trip;
  logic blk_ff, nxt_blk;
  logic evt_ff, nxt_evt;

  always_comb begin
    // Zone pick-up from sensors
    // any enabled channel
    sens   = |((light_i & light_en_i) | (pres_i & pres_en_i));
    cur_ok = (!ph_en_i && !res_en_i) || (ph_en_i && ph_start_i) || (res_en_i && res_start_i);
    pickup = 1'b0;
    if (enable_i) begin
      pickup = sens && cur_ok;
      unique case (azbs_di_mode_t'(di_mode_i))
        AZBS_DI_LIGHT:   pickup = pickup || di_i;
        AZBS_DI_CURRENT: pickup = pickup || (di_i && sens);
        default:         pickup = pickup;
      endcase
    end
  end

  always_comb begin
    nxt_trip = trip_ff;
    nxt_blk  = blk_ff;
    nxt_evt  = 1'b0;
    if (eval_i) begin
      if (!pickup) begin
        nxt_trip = 1'b0;
        nxt_blk  = 1'b0;
      end else if (block_i) begin
        nxt_evt  = !blk_ff;
        nxt_trip = 1'b0;
        nxt_blk  = 1'b1;
      end else if (!blk_ff) begin
        nxt_trip = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      trip_ff <= 1'b0;
      blk_ff  <= 1'b0;
      evt_ff  <= 1'b0;
    end else begin
      trip_ff <= nxt_trip;
      blk_ff  <= nxt_blk;
      evt_ff  <= nxt_evt;
    end
  end

  assign trip_o      = trip_ff;
  assign blocked_o   = blk_ff;
  assign block_evt_o = evt_ff;
endmodule

// [tb/azbs_partner.sv]
// Blocking matrix model driving the blocking input
`timescale 1ns/1ps
module azbs_partner (
  input  wire logic clk_sys_i,
  input  wire logic req_i,
  output logic      block_o
);
  initial begin
    block_o = 1'b0;
    forever @(negedge clk_sys_i) block_o <= req_i;
  end
endmodule

// [tb/azbs_top_bench.sv]
// Testbench for the arc zone blocking block
`timescale 1ns/1ps
module azbs_top_bench;
  import azbs_pkg::*;
  logic        clk_sys_i, reset_i, tk, req, di, ph, rs, iof, note, evt;
  logic [3:0]  zen, phe, rse, li, pr, sf, trip, blkd, zones, cond;
  logic [15:0] len, pen, cur, ea, eb, ec, er;
  logic [7:0]  dim;
  logic [31:0] et;
  logic [1:0]  ft;
  logic [4:0]  ss;
  wire         blk;
  int          n_fail, num_checks, n_evt, n_note;
  azbs_partner bm (.clk_sys_i(clk_sys_i), .req_i(req), .block_o(blk));
  azbs_top uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cycle_tick_i(tk),
    .block_i(blk), .time_i({16'h0000, cur} + 32'h1000), .cur_a_i(cur),
    .cur_b_i(cur + 16'h0001), .cur_c_i(cur + 16'h0002), .cur_res_i(cur + 16'h0003),
    .zone_en_i(zen), .zone_ph_en_i(phe), .zone_res_en_i(rse), .zone_light_en_i(len),
    .zone_pres_en_i(pen), .zone_di_mode_i(dim), .ph_start_i(ph), .res_start_i(rs),
    .light_i(li), .pres_i(pr), .di_i(di), .sensor_fault_i(sf), .io_unit_fault_i(iof),
    .zone_trip_o(trip), .zone_blocked_o(blkd), .display_notice_o(note),
    .block_evt_o(evt), .evt_time_o(et), .evt_cur_a_o(ea), .evt_cur_b_o(eb),
    .evt_cur_c_o(ec), .evt_cur_res_o(er), .evt_fault_type_o(ft), .evt_zones_o(zones),
    .zone_condition_code_o(cond), .sensor_status_o(ss));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input logic b);
    req = b;
    @(negedge clk_sys_i);
    tk = 1'b1;
    @(negedge clk_sys_i);
    tk = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask
  task automatic clr();
    {zen, phe, rse, li, pr, sf, len, pen, dim, di, ph, rs, iof} = '0;
    tick(1'b0);
  endtask
  task automatic st(input logic [4:0] e);
    repeat (2) @(negedge clk_sys_i);
    chk("status", {27'h0, e}, {27'h0, ss});
    {li, pr, sf, di, ph, rs, iof} = '0;
  endtask
  task automatic t_codes();
    for (int z = 0; z < 4; z++) for (int b = 0; b < 2; b++) begin
      clr();
      zen = 4'(1 << z);
      len = 16'(1 << (4 * z));
      li = 4'h1;
      tick(1'(b));
      chk("trip", b ? 0 : 1 << z, {28'h0, trip});
      chk("blocked", b ? 1 << z : 0, {28'h0, blkd});
      chk("cond", 2 * z + b, {28'h0, cond});
    end
    li = 4'h0;
    tick(1'b0);
    chk("release", 32'hF, {28'h0, cond});
    li = 4'h1;
    tick(1'b0);
    req = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk("block between ticks", 32'h8, {28'h0, trip});
    tk = 1'b1;
    @(posedge clk_sys_i);
    req = 1'b0;
    @(negedge clk_sys_i);
    tk = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk("sampled block", 32'h8, {28'h0, blkd});
    chk("trip to blocked", 32'h0, {28'h0, trip});
  endtask
  task automatic t_event();
    int k, kn;
    clr();
    zen = 4'h2;
    pen = 16'h0020;
    pr = 4'h2;
    cur = 16'h0ABC;
    k = n_evt;
    kn = n_note;
    tick(1'b1);
    chk("events", k + 1, n_evt);
    chk("zones", 32'h2, {28'h0, zones});
    chk("time", 32'h1ABC, et);
    chk("cur ab", 32'h0ABC0ABD, {ea, eb});
    chk("cur c res", 32'h0ABE0ABF, {ec, er});
    chk("ftype", {30'h0, FT_SENSOR}, {30'h0, ft});
    tick(1'b0);
    chk("held blocked", 32'h2, {28'h0, blkd});
    chk("no trip", 32'h0, {28'h0, trip});
    chk("no new event", k + 1, n_evt);
    chk("notices", kn + 1, n_note);
    pr = 4'h0;
    tick(1'b0);
    {pr, ph} = {4'h2, 1'b1};
    tick(1'b1);
    chk("ftype phase", {30'h0, FT_PHASE}, {30'h0, ft});
    chk("zones again", 32'h2, {28'h0, zones});
    chk("notices again", kn + 2, n_note);
  endtask
  task automatic t_qual();
    for (int m = 0; m < 3; m++) for (int s = 0; s < 2; s++) begin
      clr();
      {zen, phe, len, li} = {8'h44, 16'h0100, 4'(s)};
      dim = 8'(m << 4);
      di = 1'b1;
      tick(1'b0);
      chk("di mode", (m == 1 || (m == 2 && s == 1)) ? 4 : 0, {28'h0, trip});
    end
    clr();
    {zen, phe, len, li} = {8'h88, 16'h1000, 4'h1};
    tick(1'b0);
    chk("unqualified", 32'h0, {28'h0, trip});
    ph = 1'b1;
    tick(1'b0);
    chk("qualified", 32'h8, {28'h0, trip});
  endtask
  task automatic t_status();
    clr();
    iof = 1'b1;
    st(SC_IO_FAULT);
    sf = 4'h2;
    st(5'h0E);
    li = 4'h4;
    st(5'h08);
    pr = 4'h4;
    st(5'h09);
    di = 1'b1;
    st(SC_DIG_INPUT);
    rs = 1'b1;
    st(SC_RES_START);
    ph = 1'b1;
    st(SC_PH_START);
    st(SC_NONE);
    ph = 1'b1;
    tick(1'b1);
    st(SC_PH_BLOCKED);
    rs = 1'b1;
    tick(1'b1);
    st(SC_RES_BLOCKED);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    n_evt += int'(evt === 1'b1);
    n_note += int'(note === 1'b1);
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #(100 * 20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    {n_fail, num_checks, n_evt, n_note, tk, req, cur} = '0;
    {zen, phe, rse, li, pr, sf, len, pen, dim, di, ph, rs, iof} = '0;
    reset_i = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'b0;
    chk("reset cond", 32'hF, {28'h0, cond});
    t_codes();
    t_event();
    t_qual();
    t_status();
    end_of_test();
  end
endmodule

// [tb/azbs_top_sva.sv]
// Assertion checker for the arc zone blocking block
`timescale 1ns/1ps
module azbs_top_sva
  import azbs_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              reset_i,
  input wire logic              cycle_tick_i,
  input wire logic              block_i,
  input wire logic              io_unit_fault_i,
  input wire logic [3:0]        zone_trip_o,
  input wire logic [3:0]        zone_blocked_o,
  input wire logic              display_notice_o,
  input wire logic              block_evt_o,
  input wire logic [3:0]        evt_zones_o,
  input wire logic [3:0]        zone_condition_code_o,
  input wire logic [CODE_W-1:0] sensor_status_o
);
  logic blk_ff;
  logic nxt_blk;
  function automatic logic [3:0] cc(input logic [3:0] t, input logic [3:0] b);
    cc = ZC_NONE;
    for (int i = 3; i >= 0; i--) begin
      if (t[i]) cc = 4'(2 * i);
      else if (b[i]) cc = 4'(2 * i + 1);
    end
  endfunction
  always_comb nxt_blk = cycle_tick_i ? block_i : blk_ff;
  always_ff @(posedge clk_sys_i) blk_ff <= reset_i ? 1'b0 : nxt_blk;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_newblk;
    (zone_blocked_o & ~$past(zone_blocked_o)) != 4'h0;
  endsequence
  sequence s_newtrip;
    (zone_trip_o & ~$past(zone_trip_o)) != 4'h0;
  endsequence
  AST_TRIP_CLEAR: assert property (s_newtrip |-> !blk_ff)
    else $error("trip raised under sampled block");
  AST_BLK_SET: assert property (s_newblk |-> blk_ff)
    else $error("blocked raised without block");
  AST_EXCL: assert property ((zone_trip_o & zone_blocked_o) == 4'h0)
    else $error("trip and blocked together");
  AST_EVT_AFTER: assert property (s_newblk |=> block_evt_o)
    else $error("no event after blocking");
  AST_EVT_PAIR: assert property (block_evt_o == display_notice_o)
    else $error("notice and event differ");
  AST_EVT_ONE: assert property (block_evt_o |=> !block_evt_o)
    else $error("event longer than a cycle");
  AST_EVT_ZONES: assert property (block_evt_o |-> evt_zones_o != 4'h0 &&
    (evt_zones_o & ~zone_blocked_o) == 4'h0) else $error("bad event zones");
  AST_COND: assert property (zone_condition_code_o ==
    cc($past(zone_trip_o), $past(zone_blocked_o))) else $error("bad condition code");
  AST_TICK: assert property (zone_trip_o != $past(zone_trip_o) ||
    zone_blocked_o != $past(zone_blocked_o) |-> $past(cycle_tick_i, 2))
    else $error("decision change without tick");
  AST_IOF: assert property (io_unit_fault_i |=> sensor_status_o == SC_IO_FAULT)
    else $error("io fault code missing");
endmodule
bind azbs_top azbs_top_sva u_sva (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .cycle_tick_i(cycle_tick_i), .block_i(block_i), .io_unit_fault_i(io_unit_fault_i),
  .zone_trip_o(zone_trip_o), .zone_blocked_o(zone_blocked_o),
  .display_notice_o(display_notice_o), .block_evt_o(block_evt_o),
  .evt_zones_o(evt_zones_o), .zone_condition_code_o(zone_condition_code_o),
  .sensor_status_o(sensor_status_o));
